//--- design/dos_sequencer.sv
// Door opener sequencer: door state machine plus courtesy lamp process
module dos_sequencer #(
	parameter int unsigned TICK_CYCLES = dos_pkg::TICK_CYCLES,
	parameter int unsigned LAMP_PRESET = dos_pkg::LAMP_PRESET
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic door_button,
	input  wire logic up_limit,
	input  wire logic down_limit,
	input  wire logic obstruction_sense,
	output logic      raise_cmd,
	output logic      lower_cmd,
	output logic      lamp_out,
	output logic      lamp_timer_done
);

	typedef struct packed {
		logic [3:0]                      sync1;
		logic [3:0]                      sync2;
		dos_pkg::dos_door_e              door;
		logic                            lamp;
		logic [dos_pkg::TICK_CNT_W-1:0]  div;
		logic                            tick;
		logic [dos_pkg::LAMP_CNT_W-1:0]  lamp_cnt;
		logic                            done;
		logic                            raise;
		logic                            lower;
	} dos_state_s;

	dos_state_s st_q;
	dos_state_s st_d;

	logic btn;
	logic upl;
	logic dnl;
	logic obs;
	logic set_lamp;

	assign btn = st_q.sync2[0];
	assign upl = st_q.sync2[1];
	assign dnl = st_q.sync2[2];
	assign obs = st_q.sync2[3];

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		st_d     = st_q;
		set_lamp = 1'b0;
		// Pins pass two flops before use
		st_d.sync1 = {obstruction_sense, down_limit, up_limit, door_button};
		st_d.sync2 = st_q.sync1;

		// Door machine, one step per cycle
		case (st_q.door)
			dos_pkg::DOS_DOOR_DOWN: begin
				if (btn) begin
					st_d.door = dos_pkg::DOS_PUSH_UP;
				end
			end
			dos_pkg::DOS_PUSH_UP: begin
				if (!btn) begin
					st_d.door = dos_pkg::DOS_RAISE;
					set_lamp  = 1'b1;
				end
			end
			dos_pkg::DOS_RAISE: begin
				if (upl) begin
					st_d.door = dos_pkg::DOS_DOOR_UP;
				end
			end
			dos_pkg::DOS_DOOR_UP: begin
				if (btn) begin
					st_d.door = dos_pkg::DOS_PUSH_DOWN;
				end
			end
			dos_pkg::DOS_PUSH_DOWN: begin
				if (!btn) begin
					st_d.door = dos_pkg::DOS_LOWER;
					set_lamp  = 1'b1;
				end
			end
			dos_pkg::DOS_LOWER: begin
				// Obstruction wins over the down limit
				if (obs) begin
					st_d.door = dos_pkg::DOS_PUSH_UP;
				end else if (dnl) begin
					st_d.door = dos_pkg::DOS_DOOR_DOWN;
				end
			end
			default: begin
				st_d.door = dos_pkg::DOS_DOOR_DOWN;
			end
		endcase

		// Outputs follow the state being entered, so they drop on exit
		st_d.raise = (st_d.door == dos_pkg::DOS_RAISE);
		st_d.lower = (st_d.door == dos_pkg::DOS_LOWER);

		// Tick divider: free running, so only lamp steps after the first are a full 0.1 s
		st_d.tick = 1'b0;
		if (st_q.div >= dos_pkg::TICK_CNT_W'(TICK_CYCLES - 1)) begin
			st_d.div  = '0;
			st_d.tick = 1'b1;
		end else begin
			st_d.div = st_q.div + 1'b1;
		end

		// Lamp process, independent of door machine
		st_d.done = 1'b0;
		if (!st_q.lamp) begin
			st_d.lamp_cnt = '0;
		end else if (st_q.tick) begin
			if (st_q.lamp_cnt >=
			    dos_pkg::LAMP_CNT_W'(LAMP_PRESET - 1)) begin
				st_d.lamp_cnt = dos_pkg::LAMP_CNT_W'(LAMP_PRESET);
				st_d.done     = 1'b1;
			end else begin
				st_d.lamp_cnt = st_q.lamp_cnt + 1'b1;
			end
		end
		// New door activity restarts the lamp; set wins over the timeout
		if (set_lamp) begin
			st_d.lamp     = 1'b1;
			st_d.lamp_cnt = '0;
			st_d.done     = 1'b0;
		end else if (st_q.done) begin
			st_d.lamp     = 1'b0;
			// Count and flag drop with the lamp, so an idle timer reads zero
			st_d.lamp_cnt = '0;
			st_d.done     = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q      <= '0;
			st_q.door <= dos_pkg::DOS_DOOR_DOWN;
		end else begin
			st_q <= st_d;
		end
	end

	assign raise_cmd       = st_q.raise;
	assign lower_cmd       = st_q.lower;
	assign lamp_out        = st_q.lamp;
	assign lamp_timer_done = st_q.done;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_raise_state: assert property (
		raise_cmd == (st_q.door == dos_pkg::DOS_RAISE))
		else $error("raise_cmd does not match raise state");
	chk_lower_state: assert property (
		lower_cmd == (st_q.door == dos_pkg::DOS_LOWER))
		else $error("lower_cmd does not match lower state");
	chk_no_overlap: assert property (
		lower_cmd |=> !raise_cmd)
		else $error("raise follows lower with no gap");
	chk_obs_reverse: assert property (
		st_q.door == dos_pkg::DOS_LOWER && obs
		|=> st_q.door == dos_pkg::DOS_PUSH_UP)
		else $error("obstruction did not reverse door");
	chk_down_return: assert property (
		st_q.door == dos_pkg::DOS_LOWER && dnl && !obs
		|=> st_q.door == dos_pkg::DOS_DOOR_DOWN)
		else $error("down limit did not stop lowering");
	chk_up_stop: assert property (
		st_q.door == dos_pkg::DOS_RAISE && upl
		|=> st_q.door == dos_pkg::DOS_DOOR_UP && !raise_cmd)
		else $error("up limit did not stop raising");
	chk_lamp_set: assert property (
		st_q.door == dos_pkg::DOS_PUSH_UP && !btn |=> lamp_out)
		else $error("lamp not set on push-up release");
	chk_lamp_set_dn: assert property (
		st_q.door == dos_pkg::DOS_PUSH_DOWN && !btn |=> lamp_out)
		else $error("lamp not set on push-down release");
	chk_lamp_clear: assert property (
		lamp_timer_done && !set_lamp |=> !lamp_out)
		else $error("lamp not cleared after timeout");
	chk_timer_idle: assert property (
		!lamp_out |-> st_q.lamp_cnt == '0 && !lamp_timer_done)
		else $error("lamp timer runs while lamp off");
	chk_done_preset: assert property (
		$rose(lamp_timer_done)
		|-> st_q.lamp_cnt == dos_pkg::LAMP_CNT_W'(LAMP_PRESET))
		else $error("timer done before preset");
	chk_lamp_indep: assert property (
		lamp_timer_done && st_q.door == dos_pkg::DOS_RAISE && !upl
		|=> st_q.door == dos_pkg::DOS_RAISE)
		else $error("lamp timeout disturbed the door machine");
	chk_btn_hold: assert property (
		st_q.door == dos_pkg::DOS_PUSH_DOWN && btn
		|=> st_q.door == dos_pkg::DOS_PUSH_DOWN && !lower_cmd)
		else $error("lowering started before button release");

	cov_full_cycle: cover property (
		st_q.door == dos_pkg::DOS_LOWER && dnl && !obs);
	cov_obstruct: cover property (
		st_q.door == dos_pkg::DOS_LOWER && obs);
	cov_lamp_off: cover property (lamp_timer_done);
	cov_raise_lamp: cover property (raise_cmd && lamp_out);

endmodule

//--- inc/dos_pkg.sv
// Constants and types for the door opener sequencer
package dos_pkg;

	// Clock rate and lamp timer step
	localparam int unsigned CLK_HZ        = 200_000_000;
	localparam int unsigned TICK_MS       = 100;
	localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned LAMP_PRESET   = 1800;
	localparam int unsigned LAMP_CNT_W    = 11;
	localparam int unsigned TICK_CNT_W    = 25;

	typedef enum logic [2:0] {
		DOS_DOOR_DOWN = 3'h0,
		DOS_PUSH_UP   = 3'h1,
		DOS_RAISE     = 3'h2,
		DOS_DOOR_UP   = 3'h3,
		DOS_PUSH_DOWN = 3'h4,
		DOS_LOWER     = 3'h5
	} dos_door_e;

endpackage

//--- sim/dos_door_model.sv
// Door, motor and limit switch model for the sequencer bench
module dos_door_model #(
	parameter int TRAVEL = 20
) (
	input  wire logic clk,
	input  wire logic raise_cmd,
	input  wire logic lower_cmd,
	output logic      up_limit,
	output logic      down_limit
);
	timeunit 1ns;
	timeprecision 1ps;
	int pos = 0;
	// Door moves one step per cycle while the motor is commanded
	always @(negedge clk) begin
		if (raise_cmd && pos < TRAVEL)
			pos <= pos + 1;
		else if (lower_cmd && pos > 0)
			pos <= pos - 1;
	end
	// Switches close only at end of travel
	assign up_limit   = (pos == TRAVEL);
	assign down_limit = (pos == 0);
endmodule

//--- sim/dos_sequencer_tb_top.sv
// Self-checking bench for the door opener sequencer
module dos_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic door_button = 1'b0;
	logic obstruction_sense = 1'b0;
	logic up_limit, down_limit, raise_cmd, lower_cmd;
	logic lamp_out, lamp_timer_done;
	int   failures = 0;
	int   tests_run = 0;
	int   n;
	initial forever #2.5 clk = ~clk;
	dos_door_model i_dos_door_model (.clk(clk), .raise_cmd(raise_cmd),
		.lower_cmd(lower_cmd), .up_limit(up_limit),
		.down_limit(down_limit));
	localparam int SIM_TICK   = 4;
	localparam int SIM_PRESET = 3;
	// Free-running divider: first step lands anywhere in one tick period
	localparam int LAMP_MIN   = (SIM_PRESET - 1) * SIM_TICK + 1;
	localparam int LAMP_MAX   = SIM_PRESET * SIM_TICK;
	// Short divider and preset keep the lamp time at most a dozen cycles
	dos_sequencer #(.TICK_CYCLES(SIM_TICK), .LAMP_PRESET(SIM_PRESET))
	i_dos_sequencer (
		.clk(clk), .rst(rst), .door_button(door_button),
		.up_limit(up_limit), .down_limit(down_limit),
		.obstruction_sense(obstruction_sense), .raise_cmd(raise_cmd),
		.lower_cmd(lower_cmd), .lamp_out(lamp_out),
		.lamp_timer_done(lamp_timer_done));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string name, input logic seen, input logic exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s exp %b seen %b", name, exp, seen);
		end
	endtask
	// Bounded wait, so a stuck design cannot hang the run
	task automatic wait_hi(ref logic s);
		n = 0;
		while (s !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic tap;
		door_button = 1'b1;
		repeat (4) @(negedge clk);
		door_button = 1'b0;
	endtask
	task automatic results;
		$display("tests_run %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_open;
		tap();
		repeat (2) @(negedge clk);
		chk("raise early", raise_cmd, 1'b0);
		@(negedge clk);
		chk("raise", raise_cmd, 1'b1);
		chk("lamp", lamp_out, 1'b1);
		wait_hi(lamp_timer_done);
		chk("lamp time", n >= LAMP_MIN && n <= LAMP_MAX, 1'b1);
		chk("done", lamp_timer_done, 1'b1);
		chk("lamp before", lamp_out, 1'b1);
		@(negedge clk);
		chk("lamp off", lamp_out, 1'b0);
		chk("still raise", raise_cmd, 1'b1);
		wait_hi(up_limit);
		repeat (3) @(negedge clk);
		chk("raise stop", raise_cmd, 1'b0);
		$display("open test done");
	endtask
	task automatic t_close;
		tap();
		chk("lower early", lower_cmd, 1'b0);
		repeat (3) @(negedge clk);
		chk("lower", lower_cmd, 1'b1);
		chk("lamp set", lamp_out, 1'b1);
		repeat (5) @(negedge clk);
		obstruction_sense = 1'b1;
		repeat (3) @(negedge clk);
		chk("lower drop", lower_cmd, 1'b0);
		chk("no raise yet", raise_cmd, 1'b0);
		@(negedge clk);
		chk("reverse", raise_cmd, 1'b1);
		obstruction_sense = 1'b0;
		wait_hi(up_limit);
		repeat (4) @(negedge clk);
		tap();
		wait_hi(down_limit);
		repeat (3) @(negedge clk);
		chk("lower stop", lower_cmd, 1'b0);
		$display("close test done");
	endtask
	initial begin
		repeat (3) @(negedge clk);
		chk("reset raise", raise_cmd, 1'b0);
		chk("reset lamp", lamp_out, 1'b0);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		t_open();
		t_close();
		results();
	end
	initial begin
		#5000;
		failures++;
		results();
	end
endmodule
